// >>> fsr_cfg.svh
// Opcodes, address fields, counts and timing figures of the security register command block
`ifndef FSR_CFG_SVH
`define FSR_CFG_SVH
// Opcodes
`define FSR_OP_RESUME     8'h7A
`define FSR_OP_SR_ERASE   8'h44
`define FSR_OP_SR_PROG    8'h42
`define FSR_OP_SR_READ    8'h48
`define FSR_OP_RST_EN     8'h66
`define FSR_OP_RST        8'h99
// Address decode of a security register
`define FSR_ADDR_TOP_ZERO 8'h00
`define FSR_REG_SEL_FIRST 4'h1
`define FSR_REG_SEL_LAST  4'h3
`define FSR_REG_GAP_ZERO  3'h0
`define FSR_REG_BASE_ONE  2'h1
// Bit counter marks within a frame (count of the bit being latched)
`define FSR_CNT_ZERO      6'h00
`define FSR_CNT_OP_LAST   6'h07
`define FSR_CNT_ADDR_LAST 6'h1F
`define FSR_CNT_DATA_LOOP 6'h20
`define FSR_CNT_BYTE_LAST 6'h27
// Array content
`define FSR_ERASED_BYTE   8'hFF
`define FSR_SECREG_COUNT  3
`define FSR_SECREG_BYTES  512
// Timing figures
`define FSR_CLK_PERIOD_NS 4
`define FSR_RESUME_WIP_NS 200
`define FSR_SE_TIME_US    100
`define FSR_PP_TIME_US    20
`define FSR_RST_TIME_US   30
`endif

// >>> fsr_host.sv
// Host serial controller model that drives the link of the command block
`timescale 1ns/10ps
module fsr_host (
    output logic      o_sclk,
    output logic      o_cs_n,
    output logic      o_si,
    input  wire logic i_so
);
    // Mode 0 link clock rests low between frames
    initial begin
        o_sclk = 1'b0;
        o_cs_n = 1'b1;
        o_si   = 1'b1;
    end
    // Sends n bits MSB first, then clocks nr bits of reply in
    task automatic frame(input logic [63:0] b, input int n, input int nr, output logic [23:0] rd);
        rd = 24'h000000;
        o_cs_n = 1'b0;
        for (int i = 0; i < n + nr; i++) begin
            if (i < n) o_si = b[63 - i];
            #40 o_sclk = 1'b1;
            if (i >= n) rd = {rd[22:0], i_so};
            #40 o_sclk = 1'b0;
        end
        o_cs_n = 1'b1;
        // Released line parks at the inverse so a stale bit never passes
        o_si = ~o_si;
        #20;
    endtask
endmodule // fsr_host

// >>> fsr_pkg.sv
// Types shared by the security register command block
package fsr_pkg;
    // Fields captured from one framed command on the link
    typedef struct packed {
        logic [7:0]  op;
        logic [23:0] addr;
        logic [7:0]  data;
    } fsr_frame_type;
    // Status flags shown to the rest of the device
    typedef struct packed {
        logic write_in_progress_flag;
        logic write_enable_latch;
        logic suspend_status_flag;
        logic rst_busy;
    } fsr_status_type;
    // Kind of self-timed operation held by the core
    typedef enum logic [1:0] {
        FSR_IDLE,
        FSR_ERASE,
        FSR_PROG
    } fsr_op_type;
endpackage

// >>> fsr_secreg_cmd.sv
// Resume, security register erase/program/read and software reset command logic of a serial flash
`timescale 1ns/10ps
`include "fsr_cfg.svh"
module fsr_secreg_cmd #(
    parameter int ERASE_CYCLES = (`FSR_SE_TIME_US * 1000) / `FSR_CLK_PERIOD_NS,
    parameter int PROG_CYCLES  = (`FSR_PP_TIME_US * 1000) / `FSR_CLK_PERIOD_NS,
    parameter int RST_CYCLES   = (`FSR_RST_TIME_US * 1000) / `FSR_CLK_PERIOD_NS
) (
    input  wire logic                    i_clk,
    input  wire logic                    i_rst_n,
    input  wire logic                    i_sclk,
    input  wire logic                    i_cs_n,
    input  wire logic                    i_si,
    input  wire logic                    i_wel_set,
    input  wire logic                    i_suspend_req,
    input  wire logic                    i_sus_power_lost,
    input  wire logic [2:0]              i_lock_bits,
    output logic                         o_so,
    output logic                         o_so_oe,
    output fsr_pkg::fsr_status_type      o_status,
    output logic                         o_volatile_clr
);

    // Resume delay rounds down so busy is back inside the limit
    localparam int RESUME_CYCLES = `FSR_RESUME_WIP_NS / `FSR_CLK_PERIOD_NS;
    localparam int MEM_WORDS     = `FSR_SECREG_COUNT * `FSR_SECREG_BYTES;
    localparam int TMR_MAX       = 24'hFFFFFF;

    // ************************************************************
    // Configuration checks
    // ************************************************************
    if (ERASE_CYCLES < 1 || ERASE_CYCLES > TMR_MAX || PROG_CYCLES < 1 || PROG_CYCLES > TMR_MAX ||
        RST_CYCLES < 1 || RST_CYCLES > TMR_MAX || RESUME_CYCLES < 2 || RESUME_CYCLES > 63) begin : g_bad_cfg
        $error("fsr_secreg_cmd: cycle counts out of range");
    end

    // ************************************************************
    // Link domain: shift in on rising serial clock edges
    // ************************************************************
    logic [5:0]             lk_cnt;
    logic [6:0]             lk_shift;
    logic                   lk_dout;
    logic                   lk_len32;
    logic                   lk_op_tgl;
    logic                   lk_rd_tgl;
    logic                   lk_byte_tgl;
    logic                   lk_next_tgl;
    logic [2:0]             lk_obit;
    logic [6:0]             lk_osh;
    fsr_pkg::fsr_frame_type lk_frame;
    logic [7:0]             lk_byte_in;

    assign lk_byte_in = {lk_shift, i_si};

    // Bit position and read-data phase end with the frame; reset too, select may idle high from power-on
    always_ff @(posedge i_sclk or posedge i_cs_n or negedge i_rst_n) begin
        if (!i_rst_n || i_cs_n) begin
            lk_cnt  <= `FSR_CNT_ZERO;
            lk_dout <= 1'b0;
        end else begin
            if (lk_cnt == `FSR_CNT_BYTE_LAST) begin
                lk_cnt <= `FSR_CNT_DATA_LOOP;
            end else begin
                lk_cnt <= lk_cnt + 6'h01;
            end
            if (lk_cnt == `FSR_CNT_BYTE_LAST && lk_frame.op == `FSR_OP_SR_READ) begin
                lk_dout <= 1'b1;
            end
        end
    end

    // Opcode, address and data capture; held after the frame for the core
    always_ff @(posedge i_sclk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            lk_shift    <= 7'h00;
            lk_frame    <= '0;
            lk_len32    <= 1'b0;
            lk_op_tgl   <= 1'b0;
            lk_rd_tgl   <= 1'b0;
            lk_byte_tgl <= 1'b0;
        end else begin
            lk_shift <= lk_byte_in[6:0];
            // Only true while the frame stops exactly after address bit 24
            lk_len32 <= (lk_cnt == `FSR_CNT_ADDR_LAST);
            if (lk_cnt == `FSR_CNT_OP_LAST) begin
                lk_frame.op <= lk_byte_in;
                lk_op_tgl   <= ~lk_op_tgl;
            end
            if (lk_cnt > `FSR_CNT_OP_LAST && lk_cnt <= `FSR_CNT_ADDR_LAST) begin
                lk_frame.addr <= {lk_frame.addr[22:0], i_si};
            end
            if (lk_cnt == `FSR_CNT_ADDR_LAST && lk_frame.op == `FSR_OP_SR_READ) begin
                lk_rd_tgl <= ~lk_rd_tgl;
            end
            if (lk_cnt == `FSR_CNT_BYTE_LAST && lk_frame.op == `FSR_OP_SR_PROG) begin
                lk_frame.data <= lk_byte_in;
                lk_byte_tgl   <= ~lk_byte_tgl;
            end
        end
    end

    // ************************************************************
    // Core domain: synchronisers and events
    // ************************************************************
    logic [3:0] tg_s1;
    logic [3:0] tg_s2;
    logic [3:0] tg_s3;
    logic       cs_s1;
    logic       cs_s2;
    logic       cs_s3;

    // Two stages for the select pin and every toggle; third stage only for edges
    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            tg_s1 <= 4'h0;
            tg_s2 <= 4'h0;
            tg_s3 <= 4'h0;
            cs_s1 <= 1'b1;
            cs_s2 <= 1'b1;
            cs_s3 <= 1'b1;
        end else begin
            tg_s1 <= {lk_next_tgl, lk_byte_tgl, lk_rd_tgl, lk_op_tgl};
            tg_s2 <= tg_s1;
            tg_s3 <= tg_s2;
            cs_s1 <= i_cs_n;
            cs_s2 <= cs_s1;
            cs_s3 <= cs_s2;
        end
    end

    logic                 ev_op;
    logic                 ev_rd;
    logic                 ev_byte;
    logic                 ev_next;
    logic                 cs_rise;
    logic                 write_in_progress_flag;
    logic                 write_enable_latch;
    logic                 suspend_status_flag;
    logic                 rst_busy;
    logic                 armed;
    logic                 vol_clr;
    logic [5:0]           res_cnt;
    logic [23:0]          tmr;
    logic [23:0]          rst_cnt;
    logic [1:0]           op_reg;
    fsr_pkg::fsr_op_type  op_kind;
    logic                 prog_any;
    logic [7:0]           pg_ofs;
    logic                 rd_ok;
    logic [1:0]           rd_reg;
    logic [8:0]           rd_byte;
    logic [7:0]           rd_data;
    logic [7:0]           mem [0:MEM_WORDS-1];
    logic                 addr_ok;
    logic [1:0]           reg_idx;
    logic                 locked;
    logic                 acc;
    logic                 go_resume;
    logic                 go_reset;
    logic                 go_erase;
    logic                 go_prog;
    logic                 prog_wr;
    logic                 suspend_take;
    logic                 done;
    logic [10:0]          prog_idx;

    // Frame fields are stable whenever these events are seen
    assign ev_op   = tg_s2[0] ^ tg_s3[0];
    assign ev_rd   = tg_s2[1] ^ tg_s3[1];
    assign ev_byte = tg_s2[2] ^ tg_s3[2];
    assign ev_next = tg_s2[3] ^ tg_s3[3];
    assign cs_rise = cs_s2 & ~cs_s3;

    // Security register decode from the captured address
    assign addr_ok = lk_frame.addr[23:16] == `FSR_ADDR_TOP_ZERO &&
                     lk_frame.addr[15:12] >= `FSR_REG_SEL_FIRST &&
                     lk_frame.addr[15:12] <= `FSR_REG_SEL_LAST &&
                     lk_frame.addr[11:9] == `FSR_REG_GAP_ZERO;
    assign reg_idx = lk_frame.addr[13:12] - `FSR_REG_BASE_ONE;
    assign locked  = i_lock_bits[reg_idx];
    assign acc     = ~rst_busy;

    // ************************************************************
    // Command acceptance
    // ************************************************************
    assign go_resume    = ev_op && acc && lk_frame.op == `FSR_OP_RESUME && suspend_status_flag && !write_in_progress_flag &&
                          res_cnt == 6'h00 && !i_sus_power_lost;
    assign go_reset     = ev_op && acc && lk_frame.op == `FSR_OP_RST && armed;
    assign go_erase     = cs_rise && acc && lk_frame.op == `FSR_OP_SR_ERASE && lk_len32 && write_enable_latch &&
                          !write_in_progress_flag && !suspend_status_flag && res_cnt == 6'h00 && addr_ok && !locked;
    assign prog_wr      = ev_byte && acc && lk_frame.op == `FSR_OP_SR_PROG && write_enable_latch && !write_in_progress_flag && !suspend_status_flag &&
                          res_cnt == 6'h00 && addr_ok && !locked;
    assign go_prog      = cs_rise && acc && lk_frame.op == `FSR_OP_SR_PROG && prog_any && !write_in_progress_flag;
    assign suspend_take = i_suspend_req && write_in_progress_flag && acc && !go_reset;
    assign done         = write_in_progress_flag && tmr == 24'h000000 && op_kind != fsr_pkg::FSR_IDLE && !go_reset;
    // Byte address wraps inside its 256-byte half of the register
    assign prog_idx     = {reg_idx, lk_frame.addr[8], lk_frame.addr[7:0] + pg_ofs};

    // ************************************************************
    // Busy, latch and suspend flags with the operation timer
    // ************************************************************
    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            write_in_progress_flag     <= 1'b0;
            write_enable_latch     <= 1'b0;
            suspend_status_flag     <= 1'b0;
            res_cnt <= 6'h00;
            tmr     <= 24'h000000;
            op_reg  <= 2'h0;
            op_kind <= fsr_pkg::FSR_IDLE;
        end else if (go_reset) begin
            // Abort whatever runs or waits; suspended work is lost
            write_in_progress_flag     <= 1'b0;
            write_enable_latch     <= 1'b0;
            suspend_status_flag     <= 1'b0;
            res_cnt <= 6'h00;
            tmr     <= 24'h000000;
            op_kind <= fsr_pkg::FSR_IDLE;
        end else begin
            if (i_wel_set && acc) begin
                write_enable_latch <= 1'b1;
            end
            if (go_erase) begin
                write_in_progress_flag     <= 1'b1;
                op_kind <= fsr_pkg::FSR_ERASE;
                op_reg  <= reg_idx;
                tmr     <= 24'(ERASE_CYCLES - 1);
            end else if (go_prog) begin
                write_in_progress_flag     <= 1'b1;
                op_kind <= fsr_pkg::FSR_PROG;
                tmr     <= 24'(PROG_CYCLES - 1);
            end else if (done) begin
                write_in_progress_flag     <= 1'b0;
                write_enable_latch     <= 1'b0;
                op_kind <= fsr_pkg::FSR_IDLE;
            end else if (suspend_take) begin
                // Timer freezes so resume finishes the remaining time only
                write_in_progress_flag <= 1'b0;
                suspend_status_flag <= 1'b1;
                write_enable_latch <= 1'b0;
            end else if (go_resume) begin
                suspend_status_flag     <= 1'b0;
                res_cnt <= 6'(RESUME_CYCLES);
            end else if (res_cnt == 6'h01) begin
                res_cnt <= 6'h00;
                write_in_progress_flag     <= 1'b1;
            end else if (res_cnt != 6'h00) begin
                res_cnt <= res_cnt - 6'h01;
            end else if (write_in_progress_flag) begin
                tmr <= tmr - 24'h000001;
            end
        end
    end

    // ************************************************************
    // Software reset arming and recovery
    // ************************************************************
    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            armed    <= 1'b0;
            rst_busy <= 1'b0;
            rst_cnt  <= 24'h000000;
            vol_clr  <= 1'b0;
        end else begin
            // Mode byte and wrap bits live elsewhere; they clear on this pulse
            vol_clr <= go_reset;
            if (ev_op && acc) begin
                armed <= (lk_frame.op == `FSR_OP_RST_EN);
            end
            if (go_reset) begin
                rst_busy <= 1'b1;
                rst_cnt  <= 24'(RST_CYCLES - 1);
            end else if (rst_busy) begin
                if (rst_cnt == 24'h000000) begin
                    rst_busy <= 1'b0;
                end else begin
                    rst_cnt <= rst_cnt - 24'h000001;
                end
            end
        end
    end

    // ************************************************************
    // Program byte collection
    // ************************************************************
    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            prog_any <= 1'b0;
            pg_ofs   <= 8'h00;
        end else if (cs_rise || go_reset) begin
            prog_any <= 1'b0;
            pg_ofs   <= 8'h00;
        end else if (prog_wr) begin
            prog_any <= 1'b1;
            pg_ofs   <= pg_ofs + 8'h01;
        end
    end

    // Array: program can only clear bits, erase refills one register
    always_ff @(posedge i_clk) begin
        if (prog_wr) begin
            mem[prog_idx] <= mem[prog_idx] & lk_frame.data;
        end
        if (done && op_kind == fsr_pkg::FSR_ERASE) begin
            for (int i = 0; i < `FSR_SECREG_BYTES; i++) begin
                mem[{op_reg, 9'(i)}] <= `FSR_ERASED_BYTE;
            end
        end
    end

    // ************************************************************
    // Read pointer and prefetch for the link
    // ************************************************************
    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            rd_ok   <= 1'b0;
            rd_reg  <= 2'h0;
            rd_byte <= 9'h000;
        end else if (cs_rise || go_reset) begin
            rd_ok <= 1'b0;
        end else if (ev_rd && acc) begin
            rd_ok   <= !write_in_progress_flag && res_cnt == 6'h00 && addr_ok;
            rd_reg  <= reg_idx;
            rd_byte <= lk_frame.addr[8:0];
        end else if (ev_next && rd_ok) begin
            rd_byte <= {rd_byte[8], rd_byte[7:0] + 8'h01};
        end
    end

    // Next byte is ready long before the link asks for it
    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            rd_data <= 8'h00;
        end else begin
            rd_data <= mem[{rd_reg, rd_byte}];
        end
    end

    // ************************************************************
    // Link domain: shift out on falling serial clock edges
    // ************************************************************
    // rd_data and rd_ok are quasi-static here: settled during the dummy clocks
    always_ff @(negedge i_sclk or posedge i_cs_n or negedge i_rst_n) begin
        if (!i_rst_n) begin
            o_so        <= 1'b0;
            o_so_oe     <= 1'b0;
            lk_obit     <= 3'h0;
            lk_osh      <= 7'h00;
            lk_next_tgl <= 1'b0;
        end else if (i_cs_n) begin
            o_so    <= 1'b0;
            o_so_oe <= 1'b0;
            lk_obit <= 3'h0;
        end else if (lk_dout && rd_ok) begin
            o_so_oe <= 1'b1;
            lk_obit <= lk_obit + 3'h1;
            if (lk_obit == 3'h0) begin
                o_so        <= rd_data[7];
                lk_osh      <= rd_data[6:0];
                lk_next_tgl <= ~lk_next_tgl;
            end else begin
                o_so   <= lk_osh[6];
                lk_osh <= {lk_osh[5:0], 1'b0};
            end
        end
    end

    // Status outputs straight from their flops
    assign o_status.write_in_progress_flag      = write_in_progress_flag;
    assign o_status.write_enable_latch      = write_enable_latch;
    assign o_status.suspend_status_flag      = suspend_status_flag;
    assign o_status.rst_busy = rst_busy;
    assign o_volatile_clr    = vol_clr;

    // ************************************************************
    // Assertions
    // ************************************************************
    localparam int C_RES_WAIT = RESUME_CYCLES;

    default clocking cb @(posedge i_clk); endclocking
    default disable iff (!i_rst_n);

    sequence s_resume_taken;
        ev_op && !rst_busy && lk_frame.op == `FSR_OP_RESUME && suspend_status_flag && !write_in_progress_flag && res_cnt == 6'h00 &&
        !i_sus_power_lost;
    endsequence

    sequence s_wip_back;
        !write_in_progress_flag ##[1:C_RES_WAIT] write_in_progress_flag;
    endsequence

    resume_sus_clr_a: assert property (s_resume_taken |=> !suspend_status_flag)
        else $error("resume did not clear suspend");
    resume_wip_set_a: assert property (s_resume_taken |=> s_wip_back)
        else $error("busy not back within resume delay");
    resume_ignored_a: assert property (ev_op && lk_frame.op == `FSR_OP_RESUME && (!suspend_status_flag || write_in_progress_flag) &&
        !i_suspend_req |=> $stable(suspend_status_flag) && $stable(res_cnt))
        else $error("resume taken in wrong state");
    resume_pwrlost_a: assert property (ev_op && lk_frame.op == `FSR_OP_RESUME && i_sus_power_lost &&
        !i_suspend_req |=> $stable(suspend_status_flag))
        else $error("resume taken after power loss");
    erase_need_wel_a: assert property (cs_rise && lk_frame.op == `FSR_OP_SR_ERASE && !write_enable_latch && !write_in_progress_flag |=> !write_in_progress_flag)
        else $error("erase started without write enable");
    erase_locked_a: assert property (cs_rise && lk_frame.op == `FSR_OP_SR_ERASE && locked && !write_in_progress_flag |=> !write_in_progress_flag)
        else $error("erase started on locked register");
    erase_done_wel_a: assert property (done && op_kind == fsr_pkg::FSR_ERASE |=> !write_enable_latch && !write_in_progress_flag)
        else $error("erase end left latch or busy set");
    read_busy_a: assert property (ev_rd && write_in_progress_flag |=> !rd_ok)
        else $error("read accepted while busy");
    reset_pair_a: assert property ($rose(rst_busy) |-> $past(armed) && $past(ev_op))
        else $error("reset without enable first");
    reset_clears_a: assert property ($rose(rst_busy) |-> !write_in_progress_flag && !write_enable_latch && !suspend_status_flag && vol_clr)
        else $error("reset left volatile state");
    reset_refuse_a: assert property (rst_busy && (ev_op || cs_rise) |=> !write_in_progress_flag && $stable(write_enable_latch))
        else $error("instruction taken during reset recovery");
    prog_locked_a: assert property (ev_byte && lk_frame.op == `FSR_OP_SR_PROG && locked |=> $stable(pg_ofs))
        else $error("program byte taken for locked register");

endmodule // fsr_secreg_cmd

// >>> tb_flash_secreg_resume_reset_cmds.sv
// Self-checking bench of the security register command block
`timescale 1ns/10ps
`define CHK(a, b) begin n_tests++; if ((a) !== (b)) begin err_count++; $display("[FAIL] t=%0t got %h exp %h", $time, a, b); end end
module tb_flash_secreg_resume_reset_cmds;
    logic                    clk, rst_n, sclk, cs_n, si, wel_set, sus_req, pwr_lost, so, so_oe, vclr;
    logic [2:0]              lock;
    logic [23:0]             rd;
    fsr_pkg::fsr_status_type st;
    int                      err_count = 0;
    int                      n_tests = 0;
    int                      nclr = 0;
    int                      n_oe = 0;
    // Erase outlasts a whole read frame so the busy read is really refused
    fsr_secreg_cmd #(.ERASE_CYCLES(2000), .PROG_CYCLES(100), .RST_CYCLES(100)) fsr_secreg_cmd_inst (
        .i_clk(clk), .i_rst_n(rst_n), .i_sclk(sclk), .i_cs_n(cs_n), .i_si(si), .i_wel_set(wel_set),
        .i_suspend_req(sus_req), .i_sus_power_lost(pwr_lost), .i_lock_bits(lock), .o_so(so),
        .o_so_oe(so_oe), .o_status(st), .o_volatile_clr(vclr));
    fsr_host fsr_host_inst (.o_sclk(sclk), .o_cs_n(cs_n), .o_si(si), .i_so(so));
    initial begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end
    // Counts reset side-effect pulses
    always @(posedge clk) if (vclr === 1'b1) nclr++;
    // Counts link edges on which the output line is driven
    always @(posedge sclk) if (so_oe === 1'b1) n_oe++;
    task automatic finish_test();
        $display("checks %0d mismatches %0d", n_tests, err_count);
        if (err_count == 0 && n_tests > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask
    // Bounded wait for a status bit: 3 busy, 2 latch, 1 suspend, 0 reset busy
    task automatic wt(input int b, input logic v, input int lim);
        for (int k = 0; k < lim && st[b] !== v; k++) begin
            @(posedge clk);
            #1;
        end
        if (st[b] !== v) begin
            err_count++;
            $display("[FAIL] t=%0t wait bit %h exp %h", $time, b, v);
            finish_test();
        end
    endtask
    task automatic pulse(input logic w);
        @(posedge clk);
        #1 if (w) wel_set = 1'b1; else sus_req = 1'b1;
        @(posedge clk);
        #1 wel_set = 1'b0;
        sus_req = 1'b0;
    endtask
    task automatic fr(input logic [63:0] b, input int n, input int nr);
        fsr_host_inst.frame(b, n, nr, rd);
    endtask
    task automatic t_erase();
        fr({8'h44, 24'h001000, 32'h0}, 32, 0);
        `CHK(st.write_in_progress_flag, 1'b0)
        pulse(1'b1);
        fr({8'h44, 24'h001000, 32'h0}, 33, 0);
        `CHK(st, 4'h4)
        fr({8'h44, 24'h001000, 32'h0}, 32, 0);
        `CHK(st.write_in_progress_flag, 1'b1)
        fr({8'h48, 24'h001000, 32'h0}, 40, 24);
        `CHK(rd, 24'h000000)
        `CHK(n_oe, 0)
        wt(3, 1'b0, 2500);
        `CHK(st.write_enable_latch, 1'b0)
        $display("erase test done");
    endtask
    task automatic t_prog();
        pulse(1'b1);
        fr({8'h42, 24'h0010FF, 8'hA5, 8'h3C, 16'h0}, 48, 0);
        `CHK(st.write_in_progress_flag, 1'b1)
        wt(3, 1'b0, 400);
        `CHK(st.write_enable_latch, 1'b0)
        fr({8'h48, 24'h0010FF, 32'h0}, 40, 24);
        `CHK(rd, 24'hA53CFF)
        `CHK(n_oe, 24)
        $display("program test done");
    endtask
    task automatic t_lock();
        lock = 3'h1;
        pulse(1'b1);
        fr({8'h44, 24'h001000, 32'h0}, 32, 0);
        `CHK(st.write_in_progress_flag, 1'b0)
        fr({8'h42, 24'h001001, 8'h00, 24'h0}, 40, 0);
        fr({8'h48, 24'h0010FF, 32'h0}, 40, 24);
        `CHK(rd, 24'hA53CFF)
        `CHK(n_oe, 48)
        $display("lock test done");
    endtask
    task automatic t_resume();
        fr({8'h44, 24'h002000, 32'h0}, 32, 0);
        `CHK(st.write_in_progress_flag, 1'b1)
        pulse(1'b0);
        `CHK(st[3:1], 3'h1)
        fr({8'h7A, 56'h0}, 8, 0);
        `CHK(st.suspend_status_flag, 1'b0)
        `CHK(st.write_in_progress_flag, 1'b0)
        wt(3, 1'b1, 60);
        fr({8'h7A, 56'h0}, 8, 0);
        wt(3, 1'b0, 2500);
        `CHK(st, 4'h0)
        $display("resume test done");
    endtask
    task automatic t_power();
        pulse(1'b1);
        fr({8'h44, 24'h003000, 32'h0}, 32, 0);
        pulse(1'b0);
        pwr_lost = 1'b1;
        fr({8'h7A, 56'h0}, 8, 0);
        `CHK(st, 4'h2)
        pwr_lost = 1'b0;
        $display("power loss test done");
    endtask
    task automatic t_reset();
        pulse(1'b1);
        fr({8'h66, 56'h0}, 8, 0);
        fr({8'h48, 56'h0}, 8, 0);
        fr({8'h99, 56'h0}, 8, 0);
        `CHK(st, 4'h6)
        fr({8'h66, 56'h0}, 8, 0);
        fr({8'h99, 56'h0}, 8, 0);
        `CHK(st, 4'h1)
        `CHK(nclr, 1)
        pulse(1'b1);
        `CHK(st.write_enable_latch, 1'b0)
        wt(0, 1'b0, 400);
        $display("reset test done");
    endtask
    initial begin
        rst_n = 1'b1;
        wel_set = 1'b0;
        sus_req = 1'b0;
        pwr_lost = 1'b0;
        lock = 3'h0;
        // Reset falls after time zero so every async reset branch sees the edge
        #1 rst_n = 1'b0;
        repeat (4) @(posedge clk);
        #1 rst_n = 1'b1;
        `CHK(st, 4'h0)
        repeat (3) @(posedge clk);
        #1;
        t_erase();
        t_prog();
        t_lock();
        t_resume();
        t_power();
        t_reset();
        finish_test();
    end
endmodule // tb_flash_secreg_resume_reset_cmds
